// ### hw/bgd_gate_ctrl.sv
// Gate drive mode logic for a synchronous buck power stage
`timescale 1ns/10ps
`default_nettype none
module bgd_gate_ctrl #(
    parameter int WAKE_CYC = bgd_pkg::WAKE_CYC_DEF  // Wake bound, shortenable
) (
    input  wire logic                   clock,        // 100 MHz clock
    input  wire logic                   rst,          // Async reset, high
    input  wire logic                   uvlo_rising,  // Supply above upper threshold
    input  wire logic                   uvlo_falling, // Supply below lower threshold
    input  wire bgd_pkg::bgd_level_type pwm_in,       // Three-level PWM
    input  wire bgd_pkg::bgd_level_type skip_in,      // Three-level mode select
    input  wire logic                   zero_cross_detect, // Zero inductor current
    output var  bgd_pkg::bgd_gate_type  gate,         // Gate commands
    output var  bgd_pkg::bgd_status_type status       // Mode status
);
    import bgd_pkg::*;

    // ************************************************************
    // Input qualification
    // ************************************************************
    bgd_level_type pwm_q;                   // Qualified PWM
    bgd_level_type skip_q;                  // Qualified mode select

    bgd_tristate_filter #(.HOLD_CYC(PWM_TS_CYC)) u_pwm_filt (
        .clock     (clock),
        .rst       (rst),
        .level_in  (pwm_in),
        .level_out (pwm_q)
    );

    bgd_tristate_filter #(.HOLD_CYC(SKIP_TS_CYC)) u_skip_filt (
        .clock     (clock),
        .rst       (rst),
        .level_in  (skip_in),
        .level_out (skip_q)
    );

    // ************************************************************
    // Lockout tracking with hysteresis
    // ************************************************************
    bgd_state_type    state;                // Current state, also gates the lockout
    bgd_state_type    next_state;
    logic supply_ok;                        // Driver operational
    logic next_supply_ok;

    // Comparator is off in ultra-low, so lockout state is frozen there
    always_comb begin
        next_supply_ok = supply_ok;
        if (state != BGD_ST_ULQ) begin
            if (!supply_ok && uvlo_rising) begin
                next_supply_ok = 1'b1;
            end else if (supply_ok && uvlo_falling) begin
                next_supply_ok = 1'b0;
            end
        end
    end

    // ************************************************************
    // Mode state machine and counters
    // ************************************************************
    logic [CNT_W-1:0] ccm_cnt;              // Remaining forced CCM cycles
    logic [CNT_W-1:0] next_ccm_cnt;
    logic [CNT_W-1:0] wake_cnt;             // Wake settle counter
    logic [CNT_W-1:0] next_wake_cnt;
    logic             zx_seen;              // Zero-cross latched this low phase
    logic             next_zx_seen;

    always_comb begin
        next_state    = state;
        next_ccm_cnt  = (ccm_cnt != '0) ? ccm_cnt - CNT_W'(1) : ccm_cnt;
        next_wake_cnt = '0;
        case (state)
            BGD_ST_OFF: begin
                if (next_supply_ok) begin
                    next_state = BGD_ST_RUN;
                end
            end
            BGD_ST_RUN: begin
                if (!next_supply_ok) begin
                    next_state = BGD_ST_OFF;
                end else if (pwm_q == BGD_LVL_MID && skip_q == BGD_LVL_MID) begin
                    next_state = BGD_ST_ULQ;
                end else if (pwm_q == BGD_LVL_MID) begin
                    next_state = BGD_ST_LQ;
                end
            end
            BGD_ST_LQ: begin
                if (!next_supply_ok) begin
                    next_state = BGD_ST_OFF;
                end else if (skip_q == BGD_LVL_MID) begin
                    next_state = BGD_ST_ULQ;
                end else if (pwm_q != BGD_LVL_MID) begin
                    next_state   = BGD_ST_RUN;
                    next_ccm_cnt = CNT_W'(CCM_HOLD_CYC);
                end
            end
            BGD_ST_ULQ: begin
                if (skip_q == BGD_LVL_LOW) begin
                    next_state = BGD_ST_WAKE;
                end
            end
            BGD_ST_WAKE: begin
                next_wake_cnt = wake_cnt + CNT_W'(1);
                if (!next_supply_ok) begin
                    next_state = BGD_ST_OFF;
                end else if (wake_cnt >= CNT_W'(WAKE_WAKE_CYC - 1)) begin
                    next_state   = (pwm_q == BGD_LVL_MID) ? BGD_ST_LQ : BGD_ST_RUN;
                    next_ccm_cnt = CNT_W'(CCM_HOLD_CYC);  // Comparator settles too
                end
            end
            default: begin
                next_state = BGD_ST_OFF;
            end
        endcase
    end

    // ************************************************************
    // Gate decision
    // ************************************************************
    bgd_gate_type   next_gate;
    bgd_status_type next_status;
    logic           zx_armed;               // Zero-cross comparator enabled

    // Mode select only matters outside the CCM hold; high means FCCM
    assign zx_armed = (skip_q == BGD_LVL_LOW) && (next_ccm_cnt == '0);

    always_comb begin
        next_gate    = '0;                  // Default: all three gates low
        next_zx_seen = 1'b0;
        if (next_state == BGD_ST_RUN) begin
            if (pwm_q == BGD_LVL_HIGH) begin
                next_gate.high_side = 1'b1;
            end else if (pwm_q == BGD_LVL_LOW) begin
                // Once zero current is seen, low side stays off this phase
                next_zx_seen = zx_seen || (zx_armed && zero_cross_detect);
                next_gate.low_side_drive = !next_zx_seen;
            end
        end
        // Exclusive by construction; guard anyway since a glitch costs a FET
        if (next_gate.high_side) begin
            next_gate.low_side_drive = 1'b0;
        end
        next_gate.boot_switch = next_gate.low_side_drive;
        next_status.low_quiescent_state       = (next_state == BGD_ST_LQ);
        next_status.ultra_low_quiescent_state = (next_state == BGD_ST_ULQ);
        next_status.zx_enabled   = zx_armed && (next_state == BGD_ST_RUN);
        next_status.ccm_forced   = (next_ccm_cnt != '0);
        next_status.uvlo_comp_on = (next_state != BGD_ST_ULQ);
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            supply_ok <= 1'b0;
            state     <= BGD_ST_OFF;
            ccm_cnt   <= '0;
            wake_cnt  <= '0;
            zx_seen   <= 1'b0;
            gate      <= '0;
            status    <= '0;
        end else begin
            supply_ok <= next_supply_ok;
            state     <= next_state;
            ccm_cnt   <= next_ccm_cnt;
            wake_cnt  <= next_wake_cnt;
            zx_seen   <= next_zx_seen;
            gate      <= next_gate;
            status    <= next_status;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence pwm_leaves_tri;
        status.low_quiescent_state ##1 !status.low_quiescent_state && (state == BGD_ST_RUN);
    endsequence

    lockout_gates_low_a: assert property (@(posedge clock) disable iff (rst)
        !supply_ok |-> gate == '0)
        else $error("gate high while locked out");
    fall_disables_a: assert property (@(posedge clock) disable iff (rst)
        supply_ok && uvlo_falling && state == BGD_ST_RUN |=> state == BGD_ST_OFF)
        else $error("falling lockout ignored");
    rise_enables_a: assert property (@(posedge clock) disable iff (rst)
        state == BGD_ST_OFF && uvlo_rising |=> state == BGD_ST_RUN)
        else $error("rising lockout ignored");
    lq_gates_low_a: assert property (@(posedge clock) disable iff (rst)
        status.low_quiescent_state |-> gate == '0)
        else $error("gate on in low quiescent state");
    ccm_hold_a: assert property (@(posedge clock) disable iff (rst)
        pwm_leaves_tri |-> status.ccm_forced && !status.zx_enabled)
        else $error("CCM hold missing after tri-state");
    fccm_no_zx_a: assert property (@(posedge clock) disable iff (rst)
        skip_q == BGD_LVL_HIGH |=> !status.zx_enabled)
        else $error("zero-cross armed in FCCM");
    ulq_comp_off_a: assert property (@(posedge clock) disable iff (rst)
        status.ultra_low_quiescent_state |-> !status.uvlo_comp_on && gate == '0)
        else $error("ultra-low state wrong");
    wake_bound_a: assert property (@(posedge clock) disable iff (rst)
        state == BGD_ST_ULQ && skip_q == BGD_LVL_LOW |-> ##[1:40] state != BGD_ST_WAKE
            && state != BGD_ST_ULQ)
        else $error("wake too slow");
    // Wake settle time must stay inside the documented wake bound
    wake_limit_a: assert property (@(posedge clock) disable iff (rst)
        state == BGD_ST_WAKE |-> wake_cnt < CNT_W'(WAKE_CYC))
        else $error("wake exceeds bound");
    pwm_high_a: assert property (@(posedge clock) disable iff (rst)
        state == BGD_ST_RUN && $past(pwm_q) == BGD_LVL_HIGH && $past(state) == BGD_ST_RUN
            |-> gate.high_side)
        else $error("high side not on for PWM high");
    no_shoot_a: assert property (@(posedge clock) disable iff (rst)
        !(gate.high_side && gate.low_side_drive))
        else $error("shoot-through");
    boot_follow_a: assert property (@(posedge clock) disable iff (rst)
        gate.boot_switch == gate.low_side_drive)
        else $error("bootstrap switch mismatch");
    zx_off_a: assert property (@(posedge clock) disable iff (rst)
        zx_armed && zero_cross_detect && pwm_q == BGD_LVL_LOW |=> !gate.low_side_drive)
        else $error("low side on after zero-cross");

endmodule : bgd_gate_ctrl
`default_nettype wire

// ### hw/bgd_pkg.sv
// Package: constants, states and carriers for the buck gate drive mode logic
package bgd_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS   = 10;    // 100 MHz system clock
    localparam int PWM_TS_NS       = 60;    // PWM tri-state activation time
    localparam int SKIP_TS_NS      = 1000;  // Mode tri-state activation time (1 us)
    localparam int CCM_HOLD_NS     = 4000;  // Forced CCM after PWM leaves tri-state (4 us)
    localparam int WAKE_MAX_NS     = 50000; // Wake from ultra-low state (50 us)
    // Least times round up, longest rounds down
    localparam int PWM_TS_CYC   = (PWM_TS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SKIP_TS_CYC  = (SKIP_TS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CCM_HOLD_CYC = (CCM_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_CYC_DEF = WAKE_MAX_NS / CLK_PERIOD_NS;
    localparam int WAKE_WAKE_CYC = 16;      // Our own wake settle time, well inside the bound
    localparam int CNT_W        = 16;       // Counter width

    // ************************************************************
    // Three-level input encoding
    // ************************************************************
    typedef enum logic [1:0] {
        BGD_LVL_LOW  = 2'h0,
        BGD_LVL_HIGH = 2'h1,
        BGD_LVL_MID  = 2'h2                 // Inside the tri-state window
    } bgd_level_type;

    // ************************************************************
    // Operating states, one-hot
    // ************************************************************
    typedef enum logic [4:0] {
        BGD_ST_OFF  = 5'h01,                // Lockout, gates low
        BGD_ST_RUN  = 5'h02,                // Normal switching
        BGD_ST_LQ   = 5'h04,                // Low quiescent state
        BGD_ST_ULQ  = 5'h08,                // Ultra-low quiescent state
        BGD_ST_WAKE = 5'h10                 // Waking from ultra-low
    } bgd_state_type;

    // Gate command carrier
    typedef struct packed {
        logic high_side;                    // Control FET gate
        logic low_side_drive;               // Sync FET gate
        logic boot_switch;                  // Bootstrap charge FET
    } bgd_gate_type;

    // Mode/status carrier
    typedef struct packed {
        logic low_quiescent_state;          // PWM tri-stated
        logic ultra_low_quiescent_state;    // Both inputs tri-stated
        logic zx_enabled;                   // Zero-cross detection armed
        logic ccm_forced;                   // Inside the post-tri-state CCM hold
        logic uvlo_comp_on;                 // Lockout comparator powered
    } bgd_status_type;

endpackage : bgd_pkg

// ### hw/bgd_tristate_filter.sv
// Tri-state window qualifier: level must dwell in the window for a time
`timescale 1ns/10ps
`default_nettype none
module bgd_tristate_filter #(
    parameter int HOLD_CYC = 6              // Cycles the window must persist
) (
    input  wire logic                 clock,     // System clock
    input  wire logic                 rst,       // Async reset, high
    input  wire bgd_pkg::bgd_level_type level_in, // Raw three-level input
    output var  bgd_pkg::bgd_level_type level_out // Qualified level
);
    import bgd_pkg::*;

    logic [CNT_W-1:0] cnt;                  // Dwell counter
    logic [CNT_W-1:0] next_cnt;
    bgd_level_type    lvl;                  // Qualified level register
    bgd_level_type    next_lvl;

    // ************************************************************
    // Dwell counting
    // ************************************************************
    // Highs and lows pass at once; only the window is delayed, so a slow edge
    // crossing the window in fewer than HOLD_CYC cycles never looks like tri-state.
    always_comb begin
        next_cnt = '0;
        next_lvl = level_in;
        if (level_in == BGD_LVL_MID) begin
            next_lvl = lvl;                 // Hold last valid level meanwhile
            if (lvl == BGD_LVL_MID) begin
                next_cnt = cnt;
            end else if (cnt >= CNT_W'(HOLD_CYC - 1)) begin
                next_lvl = BGD_LVL_MID;     // Window qualified
            end else begin
                next_cnt = cnt + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt <= '0;
            lvl <= BGD_LVL_LOW;
        end else begin
            cnt <= next_cnt;
            lvl <= next_lvl;
        end
    end

    assign level_out = lvl;

endmodule : bgd_tristate_filter
`default_nettype wire

// ### verification/bgd_pwm_model.sv
// Behavioural model of the PWM controller that drives the gate logic
`timescale 1ns/10ps
`default_nettype none
module bgd_pwm_model (
    input  wire logic                   clock,    // System clock
    input  wire logic                   sw_en,    // Free-running switching on
    input  wire logic [3:0]             on_cyc,   // High time less one
    input  wire logic [3:0]             off_cyc,  // Low time less one
    input  wire bgd_pkg::bgd_level_type pwm_req,  // Level while not switching
    input  wire bgd_pkg::bgd_level_type skip_req, // Mode select level
    output var  bgd_pkg::bgd_level_type pwm_in,   // Three-level PWM
    output var  bgd_pkg::bgd_level_type skip_in   // Three-level mode select
);
    import bgd_pkg::*;

    logic [3:0] cnt; // Phase counter

    // ************************************************************
    // Start released: the pull network parks both pins mid-window
    // ************************************************************
    initial begin
        pwm_in = BGD_LVL_MID;
        skip_in = BGD_LVL_MID;
        cnt = 4'h0;
    end

    // Requests land one edge late, like a real controller output stage
    always @(posedge clock) begin
        skip_in <= skip_req;
        if (!sw_en) begin
            pwm_in <= pwm_req; // MID models a released pin held mid-window by the pull network
            cnt <= 4'h0;
        end else if (cnt == 4'h0) begin
            pwm_in <= (pwm_in == BGD_LVL_HIGH) ? BGD_LVL_LOW : BGD_LVL_HIGH;
            cnt <= (pwm_in == BGD_LVL_HIGH) ? off_cyc : on_cyc;
        end else begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule : bgd_pwm_model
`default_nettype wire

// ### verification/test_bgd_gate_ctrl.sv
// Self-checking bench for the buck gate drive mode logic
`timescale 1ns/10ps
`default_nettype none
`define check_eq(got, exp, msg) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
        n_mismatch++; \
        $display("ERROR %0t %s", $time, msg); \
    end \
end
module test_bgd_gate_ctrl;
    import bgd_pkg::*;

    // ************************************************************
    // Signals
    // ************************************************************
    localparam int WAKE_BOUND = 500;       // Shortened wake limit
    logic           clock;                 // 100 MHz
    logic           rst;                   // Async reset
    logic           uvlo_rising;           // Supply above upper threshold
    logic           uvlo_falling;          // Supply below lower threshold
    logic           zero_cross_detect;     // Zero inductor current
    logic           sw_en;                 // Partner switching
    logic [3:0]     on_cyc;                // Partner high time
    logic [3:0]     off_cyc;               // Partner low time
    bgd_level_type  pwm_req;               // Partner PWM request
    bgd_level_type  skip_req;              // Partner mode request
    bgd_level_type  pwm_in;                // PWM pin
    bgd_level_type  skip_in;               // Mode pin
    bgd_gate_type   gate;                  // Gate commands
    bgd_status_type status;                // Mode status
    bgd_level_type  h0, h1, h2, h3;        // Sampled PWM history
    logic           mon;                   // Random-phase monitor on
    int             n_mismatch;            // Failed checks
    int             tests_run;             // All checks
    int             seed;                  // Random seed
    int             i;                     // Loop index

    bgd_gate_ctrl #(.WAKE_CYC(WAKE_BOUND)) bgd_gate_ctrl_inst (
        .clock(clock), .rst(rst), .uvlo_rising(uvlo_rising),
        .uvlo_falling(uvlo_falling), .pwm_in(pwm_in), .skip_in(skip_in),
        .zero_cross_detect(zero_cross_detect), .gate(gate), .status(status));

    bgd_pwm_model bgd_pwm_model_inst (
        .clock(clock), .sw_en(sw_en), .on_cyc(on_cyc), .off_cyc(off_cyc),
        .pwm_req(pwm_req), .skip_req(skip_req), .pwm_in(pwm_in), .skip_in(skip_in));

    // ************************************************************
    // Helpers
    // ************************************************************
    // Gate pattern a settled PWM level calls for
    function automatic bgd_gate_type exp_gate(input bgd_level_type lvl);
        bgd_gate_type g;
        g = '0;
        g.high_side = (lvl == BGD_LVL_HIGH);
        g.low_side_drive = (lvl == BGD_LVL_LOW);
        g.boot_switch = (lvl == BGD_LVL_LOW);
        return g;
    endfunction : exp_gate

    task automatic go(input int n);
        repeat (n) @(posedge clock);
    endtask : go

    task automatic end_test(input string name);
        $display("test %s done, %0d mismatches so far", name, n_mismatch);
    endtask : end_test

    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Every cycle: no shoot-through; in the random phase, gates follow settled PWM
    always @(negedge clock) begin
        h3 = h2;
        h2 = h1;
        h1 = h0;
        h0 = pwm_in;
        if (!rst) begin
            `check_eq(gate.high_side & gate.low_side_drive, 1'b0, "shoot-through")
            `check_eq(gate.boot_switch, gate.low_side_drive, "boot switch")
        end
        if (mon && h0 == h1 && h1 == h2 && h2 == h3) begin
            `check_eq(gate, exp_gate(h0), "gate vs pwm")
        end
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        {rst, uvlo_rising, uvlo_falling, zero_cross_detect, sw_en, mon} = 6'h20;
        {on_cyc, off_cyc, n_mismatch, tests_run} = '0;
        h0 = BGD_LVL_LOW;
        h1 = BGD_LVL_LOW;
        h2 = BGD_LVL_LOW;
        h3 = BGD_LVL_LOW;
        pwm_req = BGD_LVL_LOW;
        skip_req = BGD_LVL_LOW;
        seed = 50;
        go(8);
        rst <= 1'b0;
        // Supply still rising: partner switches, gates must stay low
        sw_en <= 1'b1;
        {on_cyc, off_cyc} <= 8'h55;
        for (i = 0; i < 40; i++) begin
            @(negedge clock);
            `check_eq(gate, 3'h0, "gates in lockout")
        end
        go(1);
        sw_en <= 1'b0;
        uvlo_rising <= 1'b1;
        end_test("lockout");
        // Both modes: high/low phases and zero-cross response
        for (i = 0; i < 2; i++) begin
            go(1);
            skip_req <= i ? BGD_LVL_HIGH : BGD_LVL_LOW;
            pwm_req <= BGD_LVL_HIGH;
            go(4);
            @(negedge clock);
            `check_eq(gate, exp_gate(BGD_LVL_HIGH), "high phase")
            go(1);
            pwm_req <= BGD_LVL_LOW;
            go(4);
            @(negedge clock);
            `check_eq(gate, exp_gate(BGD_LVL_LOW), "low phase")
            `check_eq(status.zx_enabled, i == 0, "zero-cross arming")
            go(1);
            zero_cross_detect <= 1'b1;
            go(3);
            @(negedge clock);
            `check_eq(gate.low_side_drive, i == 1, "zero-cross response")
            go(1);
            zero_cross_detect <= 1'b0;
        end
        end_test("modes");
        // Random switching with random mode select
        mon <= 1'b1;
        sw_en <= 1'b1;
        for (i = 0; i < 12; i++) begin
            on_cyc <= 4'h3 + 4'($random(seed) & 7);
            off_cyc <= 4'h3 + 4'($random(seed) & 7);
            skip_req <= ($random(seed) & 1) ? BGD_LVL_HIGH : BGD_LVL_LOW;
            go(40);
        end
        {mon, sw_en} <= 2'h0;
        pwm_req <= BGD_LVL_HIGH;
        go(5);
        end_test("random switching");
        // PWM window: late recognition, then fast exit into CCM hold
        pwm_req <= BGD_LVL_MID;
        go(5);
        @(negedge clock);
        `check_eq(status.low_quiescent_state, 1'b0, "window taken early")
        `check_eq(gate.high_side, 1'b1, "gate dropped early")
        go(6);
        @(negedge clock);
        `check_eq(gate, 3'h0, "gates in window")
        `check_eq(status.low_quiescent_state, 1'b1, "low quiescent")
        go(1);
        pwm_req <= BGD_LVL_HIGH;
        skip_req <= BGD_LVL_LOW;
        go(4);
        @(negedge clock);
        `check_eq(gate.high_side, 1'b1, "slow window exit")
        `check_eq(status.ccm_forced, 1'b1, "hold not started")
        go(1);
        pwm_req <= BGD_LVL_LOW;
        zero_cross_detect <= 1'b1;
        go(5);
        @(negedge clock);
        `check_eq(gate.low_side_drive, 1'b1, "zero-cross in hold")
        go(370);
        @(negedge clock);
        `check_eq(status.ccm_forced, 1'b1, "hold too short")
        go(40);
        @(negedge clock);
        `check_eq(status.ccm_forced, 1'b0, "hold too long")
        `check_eq(gate.low_side_drive, 1'b0, "zero-cross after hold")
        go(1);
        zero_cross_detect <= 1'b0;
        pwm_req <= BGD_LVL_MID;
        end_test("pwm window");
        // Both pins in window: ultra-low state, lockout ignored, wake
        go(12);
        skip_req <= BGD_LVL_MID;
        go(90);
        @(negedge clock);
        `check_eq(status.ultra_low_quiescent_state, 1'b0, "mode window early")
        go(20);
        @(negedge clock);
        `check_eq(status.ultra_low_quiescent_state, 1'b1, "no ultra-low")
        `check_eq(status.uvlo_comp_on, 1'b0, "comparator on")
        `check_eq(gate, 3'h0, "gates in ultra-low")
        go(1);
        {uvlo_rising, uvlo_falling} <= 2'h1;
        skip_req <= BGD_LVL_HIGH;
        go(5);
        @(negedge clock);
        `check_eq(status.ultra_low_quiescent_state, 1'b1, "left ultra-low")
        go(1);
        {uvlo_rising, uvlo_falling} <= 2'h2;
        skip_req <= BGD_LVL_LOW;
        for (i = 0; i < WAKE_BOUND; i++) begin
            @(negedge clock);
            if (status.ultra_low_quiescent_state === 1'b0) break;
        end
        `check_eq(i < WAKE_BOUND, 1'b1, "wake timeout")
        go(20);
        pwm_req <= BGD_LVL_HIGH;
        go(4);
        @(negedge clock);
        `check_eq(gate.high_side, 1'b1, "pulse after wake")
        `check_eq(status.uvlo_comp_on, 1'b1, "comparator off")
        end_test("ultra-low");
        // Supply falls while switching
        go(1);
        sw_en <= 1'b1;
        go(20);
        {uvlo_rising, uvlo_falling} <= 2'h1;
        go(4);
        for (i = 0; i < 30; i++) begin
            @(negedge clock);
            `check_eq(gate, 3'h0, "gates after supply loss")
        end
        end_test("supply loss");
        print_verdict();
    end
endmodule : test_bgd_gate_ctrl
`default_nettype wire
